/* File: coc_pkg.sv */
package coc_pkg;
  localparam int CLK_FREQ_MHZ = 25;
  localparam int NUM_CHAN = 4;
  // Start-up interval and wait tick, in microseconds
  localparam int INIT_TIME_US = 1000;
  localparam int TICK_TIME_US = 1000;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_FREQ_MHZ;
  localparam int TICK_CYCLES = TICK_TIME_US * CLK_FREQ_MHZ;

  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
  localparam logic [7:0] CMD_CHAN_CFG = 8'hd0;
  localparam logic [7:0] PAGE_ALL = 8'hff;

  localparam logic [7:0] ON_OFF_CFG_RESET = 8'h12;
  localparam logic [15:0] CHAN_CFG_RESET = 16'h0080;
  localparam logic [7:0] ON_OFF_WR_MASK = 8'h1d;
  localparam logic [7:0] ON_OFF_RD_ONES = 8'h02;
  localparam logic [15:0] CHAN_CFG_WR_MASK = 16'h7fff;
  localparam logic [1:0] OP_CTRL_RESET = 2'h0;

  localparam int OOC_CONTROLLED_ON = 4;
  localparam int OOC_USE_BUS = 3;
  localparam int OOC_USE_PIN = 2;
  localparam int OOC_FAST_OFF = 0;
  localparam int CC_CASCADE_ON = 14;
  localparam int CC_PIN_SEL_HI = 13;
  localparam int CC_PIN_SEL_LO = 12;
  localparam int CC_FAST_SERVO_OFF = 11;
  localparam int CC_SUP_LOW_RES = 10;
  localparam int OP_CTRL_HI = 7;
  localparam int OP_CTRL_LO = 6;

  localparam logic [1:0] OP_IMMEDIATE_OFF = 2'b00;
  localparam logic [1:0] OP_SEQUENCE_OFF = 2'b01;
  localparam logic [1:0] OP_SEQUENCE_ON = 2'b10;

  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_WAIT_ON = 2'b01,
    CH_ON = 2'b11,
    CH_WAIT_OFF = 2'b10
  } coc_chan_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [7:0] code;
    logic [15:0] data;
  } coc_cmd_type;

  typedef struct packed {
    logic [15:0] init_cnt;
    logic init_done;
    logic [15:0] tick_cnt;
    logic tick;
    logic [NUM_CHAN-1:0][7:0] on_off_cfg;
    logic [NUM_CHAN-1:0][15:0] chan_cfg;
    logic [NUM_CHAN-1:0][1:0] op_ctrl;
    logic [NUM_CHAN-1:0] pin_prev;
    logic [NUM_CHAN-1:0][15:0] wait_cnt;
    logic [NUM_CHAN-1:0][1:0] chan_state;
    logic [NUM_CHAN-1:0] chan_on;
    logic [NUM_CHAN-1:0] fast_off;
    logic [NUM_CHAN-1:0] fast_servo_en;
    logic [NUM_CHAN-1:0] sup_low_res;
    logic [15:0] rd_data;
    logic rd_valid;
  } coc_state_type;
endpackage : coc_pkg

/* File: coc_channel_on_off_control.sv */
// Function
// [RULE1] On/off configuration accepts writes to the all-channels page as well as single pages.
// [RULE2] Sequencing starts only while the input voltage comparator is above its on threshold.
// [RULE3] After power-up an initialization interval passes before turn-on wait timers may run.
// [RULE4] An external pin driver holds off for the minimum off interval before on again.
// [RULE5] Host waits one telemetry refresh interval after turn-on before trusting readback.
// [RULE6] On/off reads zero in bits 7:5, one in bit 1; channel config bit 15 reads zero.
// [RULE7] Controlled-on clear: channel powers up with sequencing; zero wait turns on at once.
// [RULE8] Controlled-on set: only enabled sources start it; no source enabled means never.
// [RULE9] Bus enable clear ignores the operation control field; set obeys it.
// [RULE10] Pin enable set requires the selected pin asserted, plus bus on-command if enabled.
// [RULE11] Pin turn-off uses turn-off wait, or with fast-off set stops output immediately.
// [RULE12] Cascade bit makes selected pin an on trigger; turn-off stays time based.
// [RULE13] Two-bit field picks which of four control pins drives the channel.
// [RULE14] Fast-servo disable bit: zero enables fast servo, one disables it.
// [RULE15] Supervisor resolution bit: zero high resolution, one coarse wide range.
// [RULE16] Operation control field: 00 immediate off, 10 sequence on, 01 sequence off.
// [RULE17] On/off configuration resets to 12h, controlled-on with no source enabled, so never starts.
// [RULE18] With both sources enabled, start needs pin asserted and bus on-command.
`timescale 1ns/100ps
module coc_channel_on_off_control
  import coc_pkg::*;
#(
  parameter int INIT_COUNT = INIT_CYCLES,
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic [NUM_CHAN-1:0] control_pins_i,
  input wire logic input_above_on_i,
  input wire logic [NUM_CHAN-1:0][15:0] turn_on_wait_i,
  input wire logic [NUM_CHAN-1:0][15:0] turn_off_wait_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic [NUM_CHAN-1:0] channel_on_o,
  output logic [NUM_CHAN-1:0] fast_off_o,
  output logic [NUM_CHAN-1:0] fast_servo_en_o,
  output logic [NUM_CHAN-1:0] sup_low_res_o
);

  localparam logic [15:0] INIT_LAST = 16'(INIT_COUNT - 1);
  localparam logic [15:0] TICK_LAST = 16'(TICK_COUNT - 1);

  coc_state_type state_reg;
  coc_state_type state_next;
  coc_cmd_type cmd;

  assign cmd = '{wr: cmd_wr_i, rd: cmd_rd_i, page: cmd_page_i, code: cmd_code_i,
                 data: cmd_data_i};

  function automatic logic page_hit(input logic [7:0] page, input int ch,
                                    input logic allow_all);
    page_hit = (page == 8'(ch)) || (allow_all && page == PAGE_ALL);
  endfunction : page_hit

  function automatic logic [7:0] on_off_view(input logic [7:0] cfg);
    on_off_view = (cfg & ON_OFF_WR_MASK) | ON_OFF_RD_ONES; // [RULE6]
  endfunction : on_off_view

  always_comb begin
    logic [7:0] cfg;
    logic [15:0] cc;
    logic pin;
    logic pin_rise;
    logic bus_on;
    logic bus_imm_off;
    logic bus_seq_off;
    logic pin_off;
    logic want_on;
    logic go_imm_off;
    logic go_seq_off;
    logic [1:0] rd_ch;
    cfg = '0;
    cc = '0;
    pin = 1'b0;
    pin_rise = 1'b0;
    bus_on = 1'b0;
    bus_imm_off = 1'b0;
    bus_seq_off = 1'b0;
    pin_off = 1'b0;
    want_on = 1'b0;
    go_imm_off = 1'b0;
    go_seq_off = 1'b0;
    rd_ch = '0;
    state_next = state_reg;

    // Power-up interval before any wait timer may start
    if (!state_reg.init_done) begin
      if (state_reg.init_cnt == INIT_LAST) begin
        state_next.init_done = 1'b1; // [RULE3]
      end else begin
        state_next.init_cnt = state_reg.init_cnt + 16'h0001;
      end
    end

    // Millisecond-style tick for the wait timers
    state_next.tick = 1'b0;
    if (state_reg.tick_cnt == TICK_LAST) begin
      state_next.tick_cnt = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 16'h0001;
    end

    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      if (cmd.wr && cmd.code == CMD_ON_OFF_CFG && page_hit(cmd.page, ch, 1'b1)) begin
        state_next.on_off_cfg[ch] = cmd.data[7:0] & ON_OFF_WR_MASK; // [RULE1] [RULE6]
      end
      if (cmd.wr && cmd.code == CMD_OPERATION && page_hit(cmd.page, ch, 1'b1)) begin
        state_next.op_ctrl[ch] = cmd.data[OP_CTRL_HI:OP_CTRL_LO];
      end
      if (cmd.wr && cmd.code == CMD_CHAN_CFG && page_hit(cmd.page, ch, 1'b0)) begin
        state_next.chan_cfg[ch] = cmd.data & CHAN_CFG_WR_MASK; // [RULE6]
      end

      cfg = state_reg.on_off_cfg[ch];
      cc = state_reg.chan_cfg[ch];
      pin = control_pins_i[cc[CC_PIN_SEL_HI:CC_PIN_SEL_LO]]; // [RULE13]
      pin_rise = pin && !state_reg.pin_prev[ch];
      state_next.pin_prev[ch] = pin;

      // Bus control field counts only when bus control is enabled
      bus_on = cfg[OOC_USE_BUS] && state_reg.op_ctrl[ch] == OP_SEQUENCE_ON; // [RULE9] [RULE16]
      bus_imm_off = cfg[OOC_USE_BUS] && state_reg.op_ctrl[ch] == OP_IMMEDIATE_OFF; // [RULE16]
      bus_seq_off = cfg[OOC_USE_BUS] && state_reg.op_ctrl[ch] == OP_SEQUENCE_OFF; // [RULE16]
      pin_off = cfg[OOC_USE_PIN] && !pin; // [RULE10]

      if (!cfg[OOC_CONTROLLED_ON]) begin
        want_on = 1'b1; // [RULE7]
      end else if (!cfg[OOC_USE_BUS] && !cfg[OOC_USE_PIN]) begin
        want_on = 1'b0; // [RULE8]
      end else begin
        // Both enabled means both must agree
        want_on = (!cfg[OOC_USE_PIN] || pin) && // [RULE8] [RULE10] [RULE18]
                  (!cfg[OOC_USE_BUS] || bus_on);
        // Cascade start fires only on the pin's rising edge
        if (cc[CC_CASCADE_ON] && cfg[OOC_USE_PIN]) begin
          want_on = want_on && pin_rise; // [RULE12]
        end
      end

      if (cfg[OOC_CONTROLLED_ON]) begin
        go_imm_off = bus_imm_off ||
                     (pin_off && cfg[OOC_FAST_OFF] && !cc[CC_CASCADE_ON]); // [RULE11]
        // Cascade has no pin-driven fast turn-off, only the timed one
        go_seq_off = bus_seq_off || // [RULE11] [RULE12]
                     (pin_off && (!cfg[OOC_FAST_OFF] || cc[CC_CASCADE_ON]));
      end

      if (state_reg.tick && state_reg.wait_cnt[ch] != 16'h0000) begin
        state_next.wait_cnt[ch] = state_reg.wait_cnt[ch] - 16'h0001;
      end

      case (coc_chan_state_type'(state_reg.chan_state[ch]))
        CH_OFF: begin
          if (want_on && state_reg.init_done && input_above_on_i) begin // [RULE2] [RULE3]
            state_next.fast_off[ch] = 1'b0;
            if (turn_on_wait_i[ch] == 16'h0000) begin
              state_next.chan_state[ch] = CH_ON; // [RULE7]
              state_next.chan_on[ch] = 1'b1;
            end else begin
              state_next.wait_cnt[ch] = turn_on_wait_i[ch];
              state_next.chan_state[ch] = CH_WAIT_ON;
            end
          end
        end
        CH_WAIT_ON: begin
          if (go_imm_off || go_seq_off) begin
            state_next.chan_state[ch] = CH_OFF;
          end else if (state_reg.wait_cnt[ch] == 16'h0000) begin
            state_next.chan_state[ch] = CH_ON;
            state_next.chan_on[ch] = 1'b1;
          end
        end
        CH_ON: begin
          if (go_imm_off) begin
            state_next.chan_state[ch] = CH_OFF; // [RULE11]
            state_next.chan_on[ch] = 1'b0;
            state_next.fast_off[ch] = 1'b1;
          end else if (go_seq_off) begin
            if (turn_off_wait_i[ch] == 16'h0000) begin
              state_next.chan_state[ch] = CH_OFF;
              state_next.chan_on[ch] = 1'b0;
            end else begin
              state_next.wait_cnt[ch] = turn_off_wait_i[ch]; // [RULE11]
              state_next.chan_state[ch] = CH_WAIT_OFF;
            end
          end
        end
        CH_WAIT_OFF: begin
          if (go_imm_off) begin
            state_next.chan_state[ch] = CH_OFF;
            state_next.chan_on[ch] = 1'b0;
            state_next.fast_off[ch] = 1'b1;
          end else if (state_reg.wait_cnt[ch] == 16'h0000) begin
            state_next.chan_state[ch] = CH_OFF;
            state_next.chan_on[ch] = 1'b0;
          end
        end
        default: begin
          state_next.chan_state[ch] = CH_OFF;
          state_next.chan_on[ch] = 1'b0;
        end
      endcase

      state_next.fast_servo_en[ch] = !cc[CC_FAST_SERVO_OFF]; // [RULE14]
      state_next.sup_low_res[ch] = cc[CC_SUP_LOW_RES]; // [RULE15]
    end

    // Reads of the all-channels page show channel 0
    state_next.rd_valid = cmd.rd;
    if (cmd.rd) begin
      rd_ch = (cmd.page == PAGE_ALL) ? 2'h0 : cmd.page[1:0];
      state_next.rd_data = '0;
      if (cmd.page == PAGE_ALL || cmd.page < 8'(NUM_CHAN)) begin
        case (cmd.code)
          CMD_ON_OFF_CFG: state_next.rd_data = {8'h00, on_off_view(state_reg.on_off_cfg[rd_ch])};
          CMD_OPERATION: state_next.rd_data = {8'h00, state_reg.op_ctrl[rd_ch], 6'h00};
          CMD_CHAN_CFG: begin
            state_next.rd_data = state_reg.chan_cfg[rd_ch] & CHAN_CFG_WR_MASK; // [RULE6]
          end
          default: state_next.rd_data = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
      for (int ch = 0; ch < NUM_CHAN; ch++) begin
        state_reg.on_off_cfg[ch] <= ON_OFF_CFG_RESET & ON_OFF_WR_MASK; // [RULE17]
        state_reg.chan_cfg[ch] <= CHAN_CFG_RESET;
        state_reg.op_ctrl[ch] <= OP_CTRL_RESET;
        state_reg.chan_state[ch] <= CH_OFF;
        state_reg.fast_servo_en[ch] <= 1'b1;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_o = state_reg.rd_data;
  assign rd_valid_o = state_reg.rd_valid;
  assign channel_on_o = state_reg.chan_on;
  assign fast_off_o = state_reg.fast_off;
  assign fast_servo_en_o = state_reg.fast_servo_en;
  assign sup_low_res_o = state_reg.sup_low_res;

endmodule : coc_channel_on_off_control

/* File: coc_checker.sv */
`timescale 1ns/100ps
module coc_checker
  import coc_pkg::*;
#(
  parameter int INIT_COUNT = INIT_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic [15:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic [NUM_CHAN-1:0] channel_on_o,
  input wire logic [NUM_CHAN-1:0] fast_off_o,
  input wire logic [NUM_CHAN-1:0] fast_servo_en_o,
  input wire logic [NUM_CHAN-1:0] sup_low_res_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic [15:0] age_reg;
  // Saturates so a long run never wraps into the quiet window
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) age_reg <= 16'h0;
    else if (age_reg != 16'hffff) age_reg <= age_reg + 16'h1;
  end
  a_rd_answer: assert property (cmd_rd_i |=> rd_valid_o)
    else $error("read not answered");
  a_no_stray_valid: assert property (!cmd_rd_i |=> !rd_valid_o)
    else $error("read valid without read");
  a_onoff_fixed_bits: assert property (cmd_rd_i && cmd_code_i == CMD_ON_OFF_CFG
    && cmd_page_i < 8'h4 |=> rd_data_o[7:5] == 3'h0 && rd_data_o[1])
    else $error("on/off fixed bits wrong");
  a_chan_top_zero: assert property (cmd_rd_i && cmd_code_i == CMD_CHAN_CFG
    |=> !rd_data_o[15]) else $error("channel cfg top bit set");
  a_servo_follows: assert property (cmd_wr_i && cmd_page_i == 8'h0
    && cmd_code_i == CMD_CHAN_CFG |=> ##1 fast_servo_en_o[0] == !$past(cmd_data_i[11], 2))
    else $error("fast servo enable wrong");
  a_sup_res_follows: assert property (cmd_wr_i && cmd_page_i == 8'h0
    && cmd_code_i == CMD_CHAN_CFG |=> ##1 sup_low_res_o[0] == $past(cmd_data_i[10], 2))
    else $error("supervisor resolution wrong");
  a_fast_off_dark: assert property ((channel_on_o & fast_off_o) == 4'h0)
    else $error("fast off with output on");
  a_init_quiet: assert property (age_reg < INIT_COUNT |-> channel_on_o == 4'h0)
    else $error("channel on during init");
  c_chan_on: cover property ($rose(channel_on_o[0]));
  c_fast_off: cover property ($rose(fast_off_o[0]));
  c_all_pages: cover property (cmd_wr_i && cmd_page_i == PAGE_ALL);
endmodule : coc_checker
bind coc_channel_on_off_control coc_checker #(.INIT_COUNT(INIT_COUNT)) u_chk (.clock_i,
  .reset_n_i, .cmd_wr_i, .cmd_rd_i, .cmd_page_i, .cmd_code_i, .cmd_data_i, .rd_data_o,
  .rd_valid_o, .channel_on_o, .fast_off_o, .fast_servo_en_o, .sup_low_res_o);

/* File: coc_pin_src.sv */
`timescale 1ns/100ps
module coc_pin_src #(
  parameter int MIN_OFF = 6
) (
  input wire logic clock_i,
  input wire logic [3:0] want_i,
  output logic [3:0] pins_o
);
  int hold [4] = '{0, 0, 0, 0};
  initial pins_o = 4'h0;
  // A request to go on again is held back for MIN_OFF cycles counted from the request
  always @(posedge clock_i) begin
    for (int k = 0; k < 4; k++) begin
      if (!want_i[k]) begin
        pins_o[k] <= 1'b0;
        hold[k] <= MIN_OFF;
      end else if (hold[k] > 0) hold[k] <= hold[k] - 1;
      else pins_o[k] <= 1'b1;
    end
  end
endmodule : coc_pin_src

/* File: coc_channel_on_off_control_tb_top.sv */
`timescale 1ns/100ps
module coc_channel_on_off_control_tb_top;
  import coc_pkg::*;
  logic clk, rst_n, wr, rd, inp, rv;
  logic [7:0] page, code;
  logic [15:0] data, rdat, v;
  logic [3:0] want, pins, on, fo, fse, slr;
  logic [3:0][15:0] ton, toff;
  logic [31:0] seed = 32'h7e500072;
  int err_count = 0;
  int n_checks = 0;
  int cfg, op;
  coc_pin_src i_pins (.clock_i(clk), .want_i(want), .pins_o(pins));
  coc_channel_on_off_control #(.INIT_COUNT(8), .TICK_COUNT(4)) i_dut (.clock_i(clk),
    .reset_n_i(rst_n), .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_page_i(page), .cmd_code_i(code),
    .cmd_data_i(data), .control_pins_i(pins), .input_above_on_i(inp), .turn_on_wait_i(ton),
    .turn_off_wait_i(toff), .rd_data_o(rdat), .rd_valid_o(rv), .channel_on_o(on),
    .fast_off_o(fo), .fast_servo_en_o(fse), .sup_low_res_o(slr));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic bit mdl_on(int c, int pin, int o, int i);
    if (i == 0) return 0;
    if (c[4] == 0) return 1;
    if (c[3:2] == 0) return 0;
    return (!c[2] || pin != 0) && (!c[3] || o == 2);
  endfunction : mdl_on
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wrc(input logic [7:0] p, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk); wr = 1'b1; page = p; code = c; data = d;
    @(negedge clk); wr = 1'b0;
  endtask : wrc
  task automatic rdc(input logic [7:0] p, input logic [7:0] c, output logic [15:0] d);
    @(negedge clk); rd = 1'b1; page = p; code = c;
    @(negedge clk); rd = 1'b0; chk(16'(rv), 16'h1); d = rdat;
  endtask : rdc
  task automatic rstc(input int n);
    @(negedge clk); rst_n = 1'b0;
    repeat (n) @(negedge clk);
    rst_n = 1'b1;
  endtask : rstc
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    // Far longer than the whole sequence needs
    #(40 * 20000);
    err_count++;
    conclude();
  end
  initial begin
    {rst_n, wr, rd, page, code, data, want, inp} = '0;
    ton = '0;
    toff = '0;
    rstc(20);
    for (int p = 0; p < 4; p++) begin
      rdc(8'(p), CMD_ON_OFF_CFG, v); chk(v, 16'h0012);
      rdc(8'(p), CMD_CHAN_CFG, v); chk(v, 16'h0080);
    end
    wrc(PAGE_ALL, CMD_ON_OFF_CFG, 16'h00ff);
    for (int p = 0; p < 4; p++) begin
      rdc(8'(p), CMD_ON_OFF_CFG, v); chk(v, 16'h001f);
    end
    wrc(8'h0, CMD_CHAN_CFG, 16'hfc00);
    rdc(8'h0, CMD_CHAN_CFG, v); chk(v, 16'h7c00);
    chk(16'(fse), 16'h000e);
    chk(16'(slr), 16'h0001);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      seed = nxt(seed);
      rstc(2);
      want = seed[7:4];
      inp = seed[8] | seed[9];
      cfg = {seed[12:10], 2'h2};
      op = seed[14] ? 2 : int'(seed[13]);
      wrc(8'h0, CMD_CHAN_CFG, {2'h0, seed[1:0], 12'h0});
      wrc(8'h0, CMD_OPERATION, {8'h0, 2'(op), 6'h0});
      wrc(8'h0, CMD_ON_OFF_CFG, 16'(cfg));
      repeat (30) @(negedge clk);
      chk(16'(on[0]), 16'(mdl_on(cfg, int'(want[seed[1:0]]), op, int'(inp))));
    end
    $display("test start conditions done");
    rstc(2);
    inp = 1'b1;
    want = 4'h0;
    toff[0] = 16'h2;
    wrc(8'h0, CMD_ON_OFF_CFG, 16'h0015);
    want = 4'h1;
    repeat (20) @(negedge clk);
    chk(16'(on[0]), 16'h1);
    want = 4'h0;
    repeat (3) @(negedge clk);
    chk(16'({on[0], fo[0]}), 16'h1);
    wrc(8'h0, CMD_ON_OFF_CFG, 16'h0014);
    want = 4'h1;
    repeat (20) @(negedge clk);
    want = 4'h0;
    repeat (3) @(negedge clk);
    chk(16'(on[0]), 16'h1);
    repeat (20) @(negedge clk);
    chk(16'(on[0]), 16'h0);
    $display("test turn off done");
    want = 4'h1;
    rstc(2);
    wrc(8'h0, CMD_CHAN_CFG, 16'h4000);
    wrc(8'h0, CMD_ON_OFF_CFG, 16'h0015);
    repeat (20) @(negedge clk);
    chk(16'(on[0]), 16'h0);
    want = 4'h0;
    repeat (10) @(negedge clk);
    want = 4'h1;
    repeat (20) @(negedge clk);
    chk(16'(on[0]), 16'h1);
    want = 4'h0;
    repeat (3) @(negedge clk);
    chk(16'(on[0]), 16'h1);
    $display("test cascade done");
    rstc(2);
    wrc(8'h0, CMD_OPERATION, 16'h0080);
    wrc(8'h0, CMD_ON_OFF_CFG, 16'h0018);
    // Host lets telemetry settle after turn-on before any readback
    repeat (20) @(negedge clk);
    chk(16'(on[0]), 16'h1);
    rdc(8'h0, CMD_OPERATION, v);
    chk(v, 16'h0080);
    wrc(8'h0, CMD_OPERATION, 16'h0040);
    repeat (3) @(negedge clk);
    chk(16'(on[0]), 16'h1);
    repeat (20) @(negedge clk);
    chk(16'(on[0]), 16'h0);
    wrc(8'h0, CMD_OPERATION, 16'h0080);
    repeat (10) @(negedge clk);
    chk(16'(on[0]), 16'h1);
    wrc(8'h0, CMD_OPERATION, 16'h0000);
    repeat (2) @(negedge clk);
    chk(16'({on[0], fo[0]}), 16'h1);
    $display("test bus control done");
    conclude();
  end
endmodule : coc_channel_on_off_control_tb_top
